// ### hdl/room_evt_pkg.sv
// Functional notes
// - On recovery objects take their configured recovery value; otherwise the valve gets zero, the switch follows the order below.
// - After recovery the disable and valve fast-travel timers stop until restarted.
// - The transmit delay follows only a voltage recovery.
// - After recovery contact position is assumed, confirmed by the next switch event.
// - Recovery switch order: recovery value, else failure behaviour, else hold.
// - Stairwell duration and permanent-on keep their values across failure.
// - A stairwell interval running at failure restarts on recovery.
// - Logic links saved at failure, restored at recovery if assigned, else made inactive; bus reset keeps them.
// - The input inactive-wait period follows only a voltage recovery.
// - Active purge restarts on recovery; block, forced, purge, adjust re-established.
// - Valve ranking: reference, block, forced, purge, adjust, control value.
// - Recovery valve value only without prior priority; new control value replaces it.
// - Automatic blind holds position; position undefined until next motion telegram.
// - Bus reset resets all states except the logic links, skipping send and switch delays.
// - Bus reset loads stairwell duration, clears disable and permanent-on, opens contact.
// - Fan-changing download: full reset, status zero except automatic, contacts open.
// - Normal download keeps objects, stops stairwell and disable timers, sends status, holds the switch contact.
// - Normal download clears an unassigned disable-time object and its block.
// - At failure each output makes one undelayed action; fan holds or stops.
// - Fast heat-up closes the contact at once when the position rises.
// - Closing lasts new on-time plus a step per position, then PWM restarts.
// - Fast cool-down opens the contact at once when the position falls.
package room_evt_pkg;

    localparam int TW = 24;
    localparam int CLK_MHZ = 10;
    localparam logic [7:0] VALVE_MAX = 8'hFF;
    localparam logic [TW-1:0] T_ONE = 24'h000001;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAIR = 8'h04;
    localparam logic [7:0] ADDR_VALVE = 8'h08;
    localparam logic [7:0] ADDR_TIMING = 8'h0C;
    localparam logic [7:0] ADDR_OBJ = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    localparam int C_REC_SW_EN = 0;
    localparam int C_REC_SW_VAL = 1;
    localparam int C_FAIL_EN = 2;
    localparam int C_FAIL_VAL = 3;
    localparam int C_LINK1_ASG = 4;
    localparam int C_LINK2_ASG = 5;
    localparam int C_DIS_ASG = 6;
    localparam int C_AUTO = 7;
    localparam int C_FAN_OFF = 8;
    localparam int C_REC_V_EN = 9;
    localparam int CTRL_W = 10;
    localparam int OBJ_PERM = 16;

    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_REF = 3'b001,
        SRC_BLOCK = 3'b010,
        SRC_FORCED = 3'b011,
        SRC_PURGE = 3'b100,
        SRC_ADJUST = 3'b101,
        SRC_CTRL = 3'b110
    } valve_src_t;

    typedef struct packed {
        logic fail;
        logic recover;
        logic bus_reset;
        logic download;
        logic fan_changed;
    } bus_evt_t;

    typedef struct packed {
        logic ref_move;
        logic block;
        logic [7:0] block_val;
        logic forced;
        logic [7:0] forced_val;
        logic purge_start;
        logic adjust;
        logic [7:0] adjust_val;
        logic ctrl_valid;
        logic [7:0] ctrl_val;
    } valve_req_t;

    typedef struct packed {
        logic prio_block;
        logic prio_forced;
        logic prio_adjust;
        logic [7:0] ctrl_val;
        logic [7:0] pos;
        valve_src_t src;
        logic contact;
        logic [TW-1:0] purge_cnt;
        logic [TW-1:0] fast_cnt;
        logic [TW-1:0] pwm_cnt;
    } valve_state_t;

endpackage

// ### hdl/room_evt_mgr.sv
`timescale 1ns/100ps
module room_evt_mgr import room_evt_pkg::*; #(
    parameter int SEND_DELAY_US = 2000,
    parameter int INPUT_WAIT_US = 5000,
    parameter int PURGE_CYCLES = 60000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bus_evt_t evt,
    input wire valve_req_t vreq,
    input wire logic sw_valid,
    input wire logic sw_val,
    input wire logic stair_trig,
    input wire logic [1:0] fan_cmd,
    input wire logic [1:0] link_valid,
    input wire logic [1:0] link_in,
    input wire logic blind_valid,
    input wire logic [7:0] blind_in,
    output logic contact,
    output logic pos_known,
    output logic valve_contact,
    output logic [7:0] valve_pos,
    output valve_src_t valve_src,
    output logic [1:0] fan_speed,
    output logic [7:0] blind_pos,
    output logic blind_pos_valid,
    output logic [1:0] link_val,
    output logic [1:0] link_act,
    output logic status_send,
    output logic inputs_enabled,
    output logic stair_active
);
    localparam logic [TW-1:0] SEND_DLY_CYC = TW'(SEND_DELAY_US * CLK_MHZ);
    localparam logic [TW-1:0] IN_WAIT_CYC = TW'(INPUT_WAIT_US * CLK_MHZ);
    localparam logic [TW-1:0] PURGE_CYC = TW'(PURGE_CYCLES);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [15:0] stair_cfg;
        logic [7:0] rec_valve;
        logic [11:0] pwm_step;
        logic [11:0] travel_step;
        logic [15:0] stair_dur;
        logic [15:0] dis_time;
        logic perm_on;
        logic failed;
        logic contact;
        logic pos_known;
        logic [TW-1:0] stair_cnt;
        logic [TW-1:0] dis_cnt;
        logic [TW-1:0] send_cnt;
        logic [TW-1:0] wait_cnt;
        logic send_pend;
        valve_state_t v;
        logic [1:0] fan;
        logic auto_status;
        logic [7:0] blind;
        logic blind_ok;
        logic [1:0] link;
        logic [1:0] link_on;
        logic status_send;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t r, n;

    function automatic logic mapped(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_STAIR || a == ADDR_VALVE ||
               a == ADDR_TIMING || a == ADDR_OBJ || a == ADDR_STATUS;
    endfunction

    function automatic logic [TW-1:0] scale(input logic [11:0] step,
                                            input logic [7:0] pos);
        return TW'({12'h000, step} * {16'h0000, pos});
    endfunction

    logic [7:0] tgt;
    valve_src_t tsrc;
    logic [7:0] diff;
    logic [TW-1:0] on_time;
    logic [TW-1:0] period;
    logic wr;

    // Valve arbitration, highest source first
    always_comb begin
        tgt = r.v.pos;
        tsrc = SRC_NONE;
        if (vreq.ref_move) begin
            tgt = r.v.pos;
            tsrc = SRC_REF;
        end else if (r.v.prio_block) begin
            tgt = vreq.block_val;
            tsrc = SRC_BLOCK;
        end else if (r.v.prio_forced) begin
            tgt = vreq.forced_val;
            tsrc = SRC_FORCED;
        end else if (r.v.purge_cnt != '0) begin
            tgt = VALVE_MAX;
            tsrc = SRC_PURGE;
        end else if (r.v.prio_adjust) begin
            tgt = vreq.adjust_val;
            tsrc = SRC_ADJUST;
        end else begin
            tgt = r.v.ctrl_val;
            tsrc = SRC_CTRL;
        end
    end

    assign diff = (tgt > r.v.pos) ? tgt - r.v.pos : r.v.pos - tgt;
    assign on_time = scale(r.pwm_step, r.v.pos);
    assign period = scale(r.pwm_step, VALVE_MAX);
    assign wr = psel && penable && r.pready && pwrite && mapped(paddr);

    always_comb begin
        n = r;
        n.status_send = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        // Access phase answers on its second cycle; write lands with pready
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            n.pslverr = !mapped(paddr);
            unique case (paddr)
                ADDR_CTRL: n.prdata = 32'(r.ctrl);
                ADDR_STAIR: n.prdata = {16'h0000, r.stair_cfg};
                ADDR_VALVE: n.prdata = {24'h000000, r.rec_valve};
                ADDR_TIMING: n.prdata = {8'h00, r.travel_step, r.pwm_step};
                ADDR_OBJ: n.prdata = {15'h0000, r.perm_on, r.dis_time};
                ADDR_STATUS: n.prdata = {6'h00, r.v.src, r.v.pos,
                    r.stair_dur[7:0], r.failed, r.blind_ok, r.send_pend,
                    r.wait_cnt == '0, r.v.contact, r.pos_known, r.contact};
                default: n.prdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                ADDR_CTRL: n.ctrl = pwdata[CTRL_W-1:0];
                ADDR_STAIR: n.stair_cfg = pwdata[15:0];
                ADDR_VALVE: n.rec_valve = pwdata[7:0];
                ADDR_TIMING: begin
                    n.pwm_step = pwdata[11:0];
                    n.travel_step = pwdata[23:12];
                end
                ADDR_OBJ: begin
                    n.dis_time = pwdata[15:0];
                    n.perm_on = pwdata[OBJ_PERM];
                end
                default: n.stair_dur = r.stair_dur;
            endcase
        end

        // Normal operation; frozen while the bus is down
        if (!r.failed) begin
            if (sw_valid) begin
                n.contact = sw_val;
                n.pos_known = 1'b1;
                if (r.dis_time != '0)
                    n.dis_cnt = TW'(r.dis_time);
            end
            if (r.dis_cnt != '0)
                n.dis_cnt = r.dis_cnt - T_ONE;
            if (stair_trig && r.dis_cnt == '0 && !r.perm_on) begin
                n.stair_cnt = TW'(r.stair_dur);
                n.contact = 1'b1;
            end else if (r.stair_cnt == T_ONE) begin
                n.stair_cnt = '0;
                n.contact = r.perm_on;
            end else if (r.stair_cnt != '0) begin
                n.stair_cnt = r.stair_cnt - T_ONE;
            end
            for (int i = 0; i < 2; i++) begin
                if (link_valid[i]) begin
                    n.link[i] = link_in[i];
                    n.link_on[i] = 1'b1;
                end
            end
            n.fan = fan_cmd;
            if (blind_valid) begin
                n.blind = blind_in;
                n.blind_ok = 1'b1;
            end
            n.v.prio_block = vreq.block;
            n.v.prio_forced = vreq.forced;
            n.v.prio_adjust = vreq.adjust;
            if (vreq.ctrl_valid)
                n.v.ctrl_val = vreq.ctrl_val;
            if (vreq.purge_start)
                n.v.purge_cnt = PURGE_CYC;
            else if (r.v.purge_cnt != '0)
                n.v.purge_cnt = r.v.purge_cnt - T_ONE;
            n.v.src = tsrc;
            if (tgt > r.v.pos) begin
                n.v.contact = 1'b1;
                n.v.fast_cnt = TW'(scale(r.pwm_step, tgt) +
                    scale(r.travel_step, diff));
                n.v.pos = tgt;
            end else if (tgt < r.v.pos) begin
                n.v.contact = 1'b0;
                n.v.fast_cnt = TW'(scale(r.pwm_step, VALVE_MAX - tgt) +
                    scale(r.travel_step, diff));
                n.v.pos = tgt;
            end else if (r.v.fast_cnt != '0) begin
                n.v.fast_cnt = r.v.fast_cnt - T_ONE;
                n.v.pwm_cnt = '0;
            end else begin
                n.v.pwm_cnt = (r.v.pwm_cnt + T_ONE >= period) ? '0 :
                    r.v.pwm_cnt + T_ONE;
                n.v.contact = r.v.pwm_cnt < on_time;
            end
            if (r.send_cnt != '0) begin
                n.send_cnt = r.send_cnt - T_ONE;
            end else if (r.send_pend) begin
                n.send_pend = 1'b0;
                n.status_send = 1'b1;
            end
            if (r.wait_cnt != '0)
                n.wait_cnt = r.wait_cnt - T_ONE;
        end

        // One event per cycle, failure ranked first
        if (evt.fail) begin
            n.failed = 1'b1;
            if (r.ctrl[C_FAIL_EN])
                n.contact = r.ctrl[C_FAIL_VAL];
            else
                n.contact = r.contact;
            n.fan = r.ctrl[C_FAN_OFF] ? 2'b00 : r.fan;
            n.v.contact = r.v.contact;
            n.v.fast_cnt = '0;
            n.link = r.link;
            n.v.prio_block = r.v.prio_block;
            n.v.prio_forced = r.v.prio_forced;
            n.v.prio_adjust = r.v.prio_adjust;
            n.v.purge_cnt = r.v.purge_cnt;
            n.blind = r.blind;
        end else if (evt.recover) begin
            n.failed = 1'b0;
            n.pos_known = 1'b0;
            if (r.ctrl[C_REC_SW_EN])
                n.contact = r.ctrl[C_REC_SW_VAL];
            else if (r.ctrl[C_FAIL_EN])
                n.contact = r.ctrl[C_FAIL_VAL];
            n.dis_cnt = '0;
            n.v.fast_cnt = '0;
            // Stairwell duration and permanent-on are simply not touched
            n.stair_dur = r.stair_dur;
            if (r.stair_cnt != '0)
                n.stair_cnt = TW'(r.stair_dur);
            n.link_on = {r.ctrl[C_LINK2_ASG] & r.link_on[1],
                         r.ctrl[C_LINK1_ASG] & r.link_on[0]};
            if (r.v.purge_cnt != '0)
                n.v.purge_cnt = PURGE_CYC;
            if (!(r.v.prio_block || r.v.prio_forced || r.v.prio_adjust ||
                  r.v.purge_cnt != '0))
                n.v.ctrl_val = r.ctrl[C_REC_V_EN] ? r.rec_valve : 8'h00;
            n.send_cnt = SEND_DLY_CYC;
            n.send_pend = 1'b1;
            n.wait_cnt = IN_WAIT_CYC;
            if (r.ctrl[C_AUTO])
                n.blind_ok = 1'b0;
        end else if (evt.bus_reset || (evt.download && evt.fan_changed)) begin
            n.contact = 1'b0;
            n.pos_known = 1'b1;
            n.stair_dur = evt.bus_reset ? r.stair_cfg : 16'h0000;
            n.dis_time = '0;
            n.perm_on = 1'b0;
            n.stair_cnt = '0;
            n.dis_cnt = '0;
            n.fan = 2'b00;
            n.v = '0;
            n.blind_ok = 1'b0;
            n.auto_status = r.auto_status & r.ctrl[C_AUTO];
            n.send_cnt = '0;
            n.send_pend = 1'b0;
            n.wait_cnt = '0;
            n.status_send = 1'b1;
            if (!evt.bus_reset) begin
                n.link = '0;
                n.link_on = '0;
            end
        end else if (evt.download) begin
            n.stair_cnt = '0;
            n.dis_cnt = '0;
            n.contact = r.contact;
            n.status_send = 1'b1;
            if (!r.ctrl[C_DIS_ASG]) begin
                n.dis_time = '0;
                n.dis_cnt = '0;
            end
        end
        if (!evt.bus_reset && !evt.download)
            n.auto_status = r.ctrl[C_AUTO];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            r <= '0;
        else
            r <= n;
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign contact = r.contact;
    assign pos_known = r.pos_known;
    assign valve_contact = r.v.contact;
    assign valve_pos = r.v.pos;
    assign valve_src = r.v.src;
    assign fan_speed = r.fan;
    assign blind_pos = r.blind;
    assign blind_pos_valid = r.blind_ok;
    assign link_val = r.link;
    assign link_act = r.link_on;
    assign status_send = r.status_send;
    assign inputs_enabled = r.wait_cnt == '0;
    assign stair_active = r.stair_cnt != '0;

    reset_opens_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.bus_reset |=> !contact && status_send)
        else $error("bus reset did not open contact");
    send_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.recover && !evt.fail |=> !status_send [*8])
        else $error("status sent inside recovery delay");
    rec_known_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.recover |=> !pos_known)
        else $error("position known right after recovery");
    rec_switch_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.recover && r.ctrl[C_REC_SW_EN] |=>
        contact == $past(r.ctrl[C_REC_SW_VAL]))
        else $error("recovery switch value not applied");
    input_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.recover |=> !inputs_enabled)
        else $error("inputs enabled during wait");
    ref_rank_a: assert property (@(posedge pclk) disable iff (!presetn)
        vreq.ref_move && !r.failed && !evt.fail && !evt.bus_reset &&
        !evt.download |=> valve_src == SRC_REF)
        else $error("reference movement not top priority");
    heat_close_a: assert property (@(posedge pclk) disable iff (!presetn)
        !r.failed && tgt > r.v.pos && !evt.fail && !evt.bus_reset &&
        !evt.download |=> valve_contact)
        else $error("fast heat-up did not close contact");
    cool_open_a: assert property (@(posedge pclk) disable iff (!presetn)
        !r.failed && tgt < r.v.pos && !evt.fail && !evt.bus_reset &&
        !evt.download |=> !valve_contact)
        else $error("fast cool-down did not open contact");
    link_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.bus_reset |=> link_val == $past(link_val))
        else $error("bus reset changed logic links");
    download_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.download && !evt.fan_changed && !evt.fail && !evt.recover &&
        !evt.bus_reset |=> contact == $past(contact))
        else $error("normal download moved contact");
endmodule

// ### dv/bus_side_model.sv
`timescale 1ns/100ps
module bus_side_model import room_evt_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] req,
    input wire logic fan_chg,
    input wire logic contact,
    output bus_evt_t evt,
    output logic [3:0] fail_moves
);
    logic failed;
    logic last;
    // One request code a cycle, so two event pulses never coincide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= '0;
            failed <= 1'b0;
            last <= 1'b0;
            fail_moves <= 4'h0;
        end else begin
            evt <= '0;
            last <= contact;
            // Relay load counts contact moves while the bus is down
            if (failed && contact != last)
                fail_moves <= fail_moves + 4'h1;
            case (req)
                3'h1: if (!failed) begin
                    evt.fail <= 1'b1;
                    failed <= 1'b1;
                    fail_moves <= 4'h0;
                end
                3'h2: if (failed) begin
                    evt.recover <= 1'b1;
                    failed <= 1'b0;
                end
                3'h3: evt.bus_reset <= 1'b1;
                3'h4: begin
                    evt.download <= 1'b1;
                    evt.fan_changed <= fan_chg;
                end
                default: ;
            endcase
        end
    end
endmodule

// ### dv/test_output_state_power_event_manager.sv
`timescale 1ns/100ps
module test_output_state_power_event_manager import room_evt_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, valve_pos, blind_pos, blind_in;
    logic [31:0] pwdata, prdata, rd;
    bus_evt_t evt;
    valve_req_t vreq;
    valve_src_t valve_src;
    logic sw_valid, sw_val, stair_trig, blind_valid, fan_chg, contact;
    logic pos_known, valve_contact, blind_pos_valid, status_send;
    logic inputs_enabled, stair_active;
    logic [1:0] fan_cmd, link_valid, link_in, fan_speed, link_val, link_act;
    logic [2:0] req;
    logic [3:0] fail_moves;
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    localparam int SEND_CYC = 1 * CLK_MHZ;
    // ctrl, switch before failure, fan in failure, contact after recovery
    localparam logic [13:0] REC_ROWS [6] = '{
        {10'h003, 1'b0, 2'h2, 1'b1}, {10'h001, 1'b1, 2'h2, 1'b0},
        {10'h00C, 1'b0, 2'h2, 1'b1}, {10'h004, 1'b1, 2'h2, 1'b0},
        {10'h100, 1'b1, 2'h0, 1'b1}, {10'h00D, 1'b1, 2'h2, 1'b0}};
    // ref, block, forced, adjust levels, winning source, position
    localparam logic [14:0] VALVE_ROWS [8] = '{
        {4'h0, SRC_CTRL, 8'h55}, {4'h1, SRC_ADJUST, 8'h44},
        {4'h3, SRC_FORCED, 8'h33}, {4'h7, SRC_BLOCK, 8'h22},
        {4'hF, SRC_REF, 8'h00}, {4'h5, SRC_BLOCK, 8'h22},
        {4'h9, SRC_REF, 8'h00}, {4'h2, SRC_FORCED, 8'h33}};

    room_evt_mgr #(.SEND_DELAY_US(1), .INPUT_WAIT_US(1), .PURGE_CYCLES(20))
        uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .evt, .vreq, .sw_valid, .sw_val,
        .stair_trig, .fan_cmd, .link_valid, .link_in, .blind_valid,
        .blind_in, .contact, .pos_known, .valve_contact, .valve_pos,
        .valve_src, .fan_speed, .blind_pos, .blind_pos_valid, .link_val,
        .link_act, .status_send, .inputs_enabled, .stair_active);
    bus_side_model far (.pclk, .presetn, .req, .fan_chg, .contact, .evt,
        .fail_moves);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            miscompares++;
            $display("BAD %0t wait ran out", $time);
            wrap_up();
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    task automatic wait_hi(ref logic s, input logic lvl, input int lim);
        for (n = 0; n < lim && s !== lvl; n++)
            cyc(1);
        bound(n, lim);
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        bound(k, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic evt_go(input logic [2:0] c);
        @(posedge pclk);
        req <= c;
        @(posedge pclk);
        req <= 3'h0;
        cyc(1);
    endtask

    // Kind 0 switch, 1 valve control value, 2 logic links
    task automatic tel(input int kind, input logic [7:0] v);
        @(posedge pclk);
        sw_valid <= kind == 0;
        vreq.ctrl_valid <= kind == 1;
        link_valid <= kind == 2 ? 2'h3 : 2'h0;
        sw_val <= v[0];
        vreq.ctrl_val <= v;
        link_in <= v[1:0];
        @(posedge pclk);
        sw_valid <= 1'b0;
        vreq.ctrl_valid <= 1'b0;
        link_valid <= 2'h0;
        #1;
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, sw_valid, sw_val, stair_trig} = '0;
        {blind_valid, fan_chg, paddr, blind_in, link_valid, link_in} = '0;
        {pwdata, req} = '0;
        vreq = '0;
        fan_cmd = 2'h2;
        repeat (2) @(posedge pclk);
        chk(contact, 1'b0, "rst contact");
        chk(pready, 1'b0, "rst pready");
        chk(inputs_enabled, 1'b1, "rst inputs");
        chk(valve_src, SRC_NONE, "rst src");
        presetn <= 1'b1;
        apb(1'b0, 8'h18, 32'h00000000);
        chk(err, 1'b1, "unmapped");
        apb(1'b1, ADDR_TIMING, 32'h00001001);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ADDR_CTRL, {22'h0, REC_ROWS[i][13:4]});
            tel(0, {7'h0, REC_ROWS[i][3]});
            evt_go(3'h1);
            chk(fan_speed, REC_ROWS[i][2:1], "fail fan");
            // Telegram while the bus is down must be ignored
            tel(0, {7'h0, ~REC_ROWS[i][3]});
            evt_go(3'h2);
            chk(contact, REC_ROWS[i][0], "rec contact");
            chk(pos_known, 1'b0, "rec pos");
            chk(fail_moves <= 4'h1, 1'b1, "fail moves");
            chk(inputs_enabled, 1'b0, "rec inputs");
            wait_hi(status_send, 1'b1, 40);
            chk(n >= SEND_CYC - 2, 1'b1, "send delay");
            wait_hi(inputs_enabled, 1'b1, 40);
            tel(0, {7'h0, ~REC_ROWS[i][0]});
            chk(pos_known, 1'b1, "pos known");
        end
        apb(1'b1, ADDR_CTRL, 32'h00000030);
        tel(2, 8'h02);
        apb(1'b1, ADDR_OBJ, 32'h00010123);
        apb(1'b1, ADDR_STAIR, 32'h00000042);
        tel(0, 8'h01);
        evt_go(3'h3);
        chk(contact, 1'b0, "reset contact");
        chk(inputs_enabled, 1'b1, "reset inputs");
        chk(link_val, 2'h2, "reset links");
        apb(1'b0, ADDR_OBJ, 32'h00000000);
        chk(rd, 32'h00000000, "reset obj");
        apb(1'b0, ADDR_STATUS, 32'h00000000);
        chk(rd[14:7], 8'h42, "reset stair");
        apb(1'b1, ADDR_CTRL, 32'h00000010);
        tel(2, 8'h03);
        evt_go(3'h1);
        tel(2, 8'h00);
        evt_go(3'h2);
        chk(link_act, 2'h1, "link act");
        chk(link_val[0], 1'b1, "link val");
        apb(1'b1, ADDR_OBJ, 32'h00000055);
        tel(0, 8'h01);
        evt_go(3'h4);
        chk(contact, 1'b1, "dl contact");
        wait_hi(status_send, 1'b1, 4);
        apb(1'b0, ADDR_OBJ, 32'h00000000);
        chk(rd[15:0], 16'h0000, "dl disable");
        apb(1'b1, ADDR_CTRL, 32'h00000050);
        apb(1'b1, ADDR_OBJ, 32'h00010055);
        evt_go(3'h4);
        apb(1'b0, ADDR_OBJ, 32'h00000000);
        chk(rd, 32'h00010055, "dl keep");
        fan_chg <= 1'b1;
        evt_go(3'h4);
        fan_chg <= 1'b0;
        chk(contact, 1'b0, "full contact");
        apb(1'b0, ADDR_OBJ, 32'h00000000);
        chk(rd, 32'h00000000, "full obj");
        apb(1'b1, ADDR_CTRL, 32'h00000080);
        blind_valid <= 1'b1;
        blind_in <= 8'h5A;
        @(posedge pclk);
        blind_valid <= 1'b0;
        evt_go(3'h1);
        evt_go(3'h2);
        chk(blind_pos, 8'h5A, "blind hold");
        chk(blind_pos_valid, 1'b0, "blind undefined");
        apb(1'b1, ADDR_CTRL, 32'h00000000);
        vreq.block_val <= 8'h22;
        vreq.forced_val <= 8'h33;
        vreq.adjust_val <= 8'h44;
        tel(1, 8'h55);
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            {vreq.ref_move, vreq.block, vreq.forced, vreq.adjust}
                <= VALVE_ROWS[i][14:11];
            cyc(2);
            chk(valve_src, VALVE_ROWS[i][10:8], "src");
            if (VALVE_ROWS[i][10:8] != SRC_REF)
                chk(valve_pos, VALVE_ROWS[i][7:0], "pos");
        end
        @(posedge pclk);
        {vreq.ref_move, vreq.block, vreq.forced, vreq.adjust} <= 4'h1;
        vreq.purge_start <= 1'b1;
        @(posedge pclk);
        vreq.purge_start <= 1'b0;
        cyc(2);
        chk(valve_src, SRC_PURGE, "purge");
        cyc(8);
        evt_go(3'h1);
        evt_go(3'h2);
        // Well past the first purge window, so only a restart explains it
        cyc(14);
        chk(valve_src, SRC_PURGE, "purge again");
        for (n = 0; n < 40 && valve_src !== SRC_ADJUST; n++)
            cyc(1);
        bound(n, 40);
        vreq.adjust <= 1'b0;
        apb(1'b1, ADDR_VALVE, 32'h00000077);
        apb(1'b1, ADDR_CTRL, 32'h00000200);
        evt_go(3'h1);
        evt_go(3'h2);
        // Position follows the restored control value one cycle later
        cyc(1);
        chk(valve_pos, 8'h77, "rec valve");
        vreq.block <= 1'b1;
        evt_go(3'h1);
        evt_go(3'h2);
        chk(valve_src, SRC_BLOCK, "rec block");
        chk(valve_pos, 8'h22, "rec block pos");
        vreq.block <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h00000000);
        tel(1, 8'h80);
        tel(1, 8'h08);
        cyc(1);
        chk(valve_contact, 1'b0, "cool");
        tel(1, 8'h90);
        cyc(1);
        chk(valve_contact, 1'b1, "heat");
        wait_hi(valve_contact, 1'b0, 1000);
        // On-time 0x90 steps plus one step per position from 0x08
        chk(n >= 280, 1'b1, "heat time");
        wrap_up();
    end
endmodule
